// ---- core/pp_dual_defs.svh ----
// Offsets, field positions, masks and reset values of the dual-buffer register set
`ifndef PP_DUAL_DEFS_SVH
`define PP_DUAL_DEFS_SVH

`define OFS_PORT_CONTROL     8'h00
`define OFS_WRITE_ADDRESS    8'h04
`define OFS_READ_ADDRESS     8'h08
`define OFS_READ_INPUT_DATA  8'h0C
`define OFS_COMMON_DATA_IN   8'h10
`define OFS_COMMON_ADDRESS   8'h14

`define BIT_DUAL_BUFFER      17
`define BIT_CHIP_SELECT      14
`define ADDR_FIELD_HI        10
`define WORD_FIELD_HI        15

`define MASK_PORT_CONTROL    32'h0002_0000
`define MASK_ADDRESS         32'h0000_47FF
`define MASK_WORD            32'h0000_FFFF
`define RESET_REG            32'h0000_0000

`endif

// ---- core/pp_dual_pkg.sv ----
// Types shared by the dual-buffer register block
package pp_dual_pkg;
   typedef enum logic [2:0] {
      CYC_IDLE  = 3'b001,
      CYC_WRITE = 3'b010,
      CYC_READ  = 3'b100
   } cycle_kind_e;
   typedef logic [31:0] reg_word_t;
endpackage

// ---- core/pin_drive.sv ----
// Registered drive of address lines and the shared chip-select / address-14 pin
`timescale 1ns/1ns
`include "pp_dual_defs.svh"
module pin_drive
   import pp_dual_pkg::*;
#(
   parameter int ADDR_W = 11
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Selected address register fields and cycle-active flag
   input  wire logic [ADDR_W-1:0] addr_field,
   input  wire logic              cs_bit,
   input  wire logic              cycle_active,
   // Pins
   output logic      [ADDR_W-1:0] pin_addr_reg,
   output logic                   chip_select_one_reg,
   output logic                   address_line_fourteen_reg
);
   wire logic [ADDR_W-1:0] addr_next = cycle_active ? addr_field : '0;
   wire logic              cs_next   = cycle_active & cs_bit; // [RULE1] [RULE3]
   // With the bit cleared the pin carries address 14, which this block drives high during an active cycle
   wire logic              a14_next  = cycle_active & ~cs_bit; // [RULE2] [RULE4]

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_addr_reg              <= '0;
         chip_select_one_reg       <= 1'b0;
         address_line_fourteen_reg <= 1'b0;
      end else begin
         pin_addr_reg              <= addr_next;
         chip_select_one_reg       <= cs_next;
         address_line_fourteen_reg <= a14_next;
      end
   end
endmodule

// ---- core/parallel_port_dual_buffer_regs.sv ----
// Dual-buffer address and read-data registers of a parallel master port
//
// Behaviour
// [RULE1] Write address: chip select bit 14, address 10:0
// [RULE2] Write select clear: pin serves as address 14
// [RULE3] Read address: chip select bit 14, address 10:0
// [RULE4] Read select clear: pin serves as address 14
// [RULE5] Separate registers used only in dual-buffer mode
// [RULE6] External read word lands in bits 15:0
// [RULE7] Dual mode reads here, else common input
// [RULE8] Unimplemented bits read back as zero
// [RULE9] Write cycles use write address, reads read address
// [RULE10] Reset clears all implemented fields to zero
`timescale 1ns/1ns
`include "pp_dual_defs.svh"
module parallel_port_dual_buffer_regs
   import pp_dual_pkg::*;
#(
   parameter int ADDR_W = 11,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata_reg,
   // Cycle sequencer, same clock
   input  wire logic              cyc_write,
   input  wire logic              cyc_read,
   input  wire logic              read_capture,
   // External data pins
   input  wire logic [DATA_W-1:0] ext_data_in,
   // Address and select pins
   output logic      [ADDR_W-1:0] pin_addr,
   output logic                   chip_select_one,
   output logic                   address_line_fourteen,
   // Mode status
   output logic                   dual_buffer_enable
);
   reg_word_t port_control_reg;
   reg_word_t write_address_reg;
   reg_word_t read_address_reg;
   reg_word_t read_input_data_reg;
   reg_word_t common_data_input_reg;
   reg_word_t common_address_reg;
   logic [DATA_W-1:0] data_meta_reg;
   logic [DATA_W-1:0] data_sync_reg;

   // Address match, shared by the write decode and the read-back mux
   function automatic logic addr_hit(logic [7:0] a, logic [7:0] ofs);
      return a == ofs;
   endfunction
   wire logic hit_ctl  = addr_hit(reg_addr, `OFS_PORT_CONTROL);
   wire logic hit_wad  = addr_hit(reg_addr, `OFS_WRITE_ADDRESS);
   wire logic hit_rad  = addr_hit(reg_addr, `OFS_READ_ADDRESS);
   wire logic hit_rdin = addr_hit(reg_addr, `OFS_READ_INPUT_DATA);
   wire logic hit_cdin = addr_hit(reg_addr, `OFS_COMMON_DATA_IN);
   wire logic hit_cad  = addr_hit(reg_addr, `OFS_COMMON_ADDRESS);

   // Write decode
   wire logic wr_ctl  = reg_wr && hit_ctl;
   wire logic wr_wad  = reg_wr && hit_wad;
   wire logic wr_rad  = reg_wr && hit_rad;
   wire logic wr_rdin = reg_wr && hit_rdin;
   wire logic wr_cdin = reg_wr && hit_cdin;
   wire logic wr_cad  = reg_wr && hit_cad;

   assign dual_buffer_enable = port_control_reg[`BIT_DUAL_BUFFER];

   // Pin data crosses in from outside, so two flops before use
   wire logic [DATA_W-1:0] captured_word = data_sync_reg;
   wire reg_word_t captured_ext = {{(32-DATA_W){1'b0}}, captured_word};

   // Capture routing; a capture beats a software write in the same cycle
   wire logic cap_dual   = read_capture & dual_buffer_enable;  // [RULE6] [RULE7]
   wire logic cap_common = read_capture & ~dual_buffer_enable; // [RULE7]

   // Cycle kind: write wins if the sequencer raises both
   wire cycle_kind_e cyc_kind = cyc_write ? CYC_WRITE : (cyc_read ? CYC_READ : CYC_IDLE);

   // Address source selection
   wire reg_word_t dual_addr = (cyc_kind == CYC_READ) ? read_address_reg
                                                      : write_address_reg; // [RULE9]
   wire reg_word_t sel_addr  = dual_buffer_enable ? dual_addr : common_address_reg; // [RULE5]

   // Next values with unimplemented bits forced to zero
   wire reg_word_t write_address_next   = reg_wdata & `MASK_ADDRESS; // [RULE1] [RULE8]
   wire reg_word_t read_address_next    = reg_wdata & `MASK_ADDRESS; // [RULE3] [RULE8]
   wire reg_word_t read_input_data_next = cap_dual ? captured_ext
                                                   : (reg_wdata & `MASK_WORD); // [RULE6] [RULE8]
   wire reg_word_t common_data_next     = cap_common ? captured_ext : (reg_wdata & `MASK_WORD);

   // Read-back mux
   wire reg_word_t rd_mux =
      hit_ctl  ? port_control_reg      :
      hit_wad  ? write_address_reg     :
      hit_rad  ? read_address_reg      :
      hit_rdin ? read_input_data_reg   :
      hit_cdin ? common_data_input_reg :
      hit_cad  ? common_address_reg    : `RESET_REG;
   wire reg_word_t reg_rdata_next = reg_rd ? rd_mux : `RESET_REG;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_meta_reg <= '0;
         data_sync_reg <= '0;
      end else begin
         data_meta_reg <= ext_data_in;
         data_sync_reg <= data_meta_reg;
      end
   end

   // [RULE10]
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_control_reg      <= `RESET_REG;
         write_address_reg     <= `RESET_REG;
         read_address_reg      <= `RESET_REG;
         read_input_data_reg   <= `RESET_REG;
         common_data_input_reg <= `RESET_REG;
         common_address_reg    <= `RESET_REG;
         reg_rdata_reg         <= `RESET_REG;
      end else begin
         if (wr_ctl) begin
            port_control_reg <= reg_wdata & `MASK_PORT_CONTROL;
         end
         if (wr_wad) begin
            write_address_reg <= write_address_next;
         end
         if (wr_rad) begin
            read_address_reg <= read_address_next;
         end
         if (wr_rdin || cap_dual) begin
            read_input_data_reg <= read_input_data_next;
         end
         if (wr_cdin || cap_common) begin
            common_data_input_reg <= common_data_next;
         end
         if (wr_cad) begin
            common_address_reg <= reg_wdata & `MASK_ADDRESS;
         end
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   // Pins are registered so they change cleanly one cycle after the cycle request
   pin_drive #(
      .ADDR_W (ADDR_W)
   ) u_pin_drive (
      .clk                       (clk),
      .sys_rst                   (sys_rst),
      .addr_field                (sel_addr[ADDR_W-1:0]),
      .cs_bit                    (sel_addr[`BIT_CHIP_SELECT]), // [RULE1] [RULE3]
      .cycle_active              (cyc_kind != CYC_IDLE),
      .pin_addr_reg              (pin_addr),
      .chip_select_one_reg       (chip_select_one),          // [RULE2] [RULE4]
      .address_line_fourteen_reg (address_line_fourteen)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_write_addr_field_store: assert property (wr_wad |=> // [RULE1]
                                   write_address_reg == ($past(reg_wdata) & `MASK_ADDRESS))
      else $error("write address not stored as masked");
   a_wcs_active: assert property (dual_buffer_enable && cyc_write && // [RULE1]
                                  write_address_reg[`BIT_CHIP_SELECT]
                                  |=> chip_select_one && !address_line_fourteen)
      else $error("write chip select not asserted");
   a_wcs_cleared: assert property (dual_buffer_enable && cyc_write && // [RULE2]
                                   !write_address_reg[`BIT_CHIP_SELECT]
                                   |=> !chip_select_one && address_line_fourteen)
      else $error("write select clear did not give address 14");
   a_read_addr_field_store: assert property (wr_rad |=> // [RULE3]
                                   read_address_reg == ($past(reg_wdata) & `MASK_ADDRESS))
      else $error("read address not stored as masked");
   a_rcs_active: assert property (dual_buffer_enable && cyc_read && !cyc_write && // [RULE3]
                                  read_address_reg[`BIT_CHIP_SELECT]
                                  |=> chip_select_one && !address_line_fourteen)
      else $error("read chip select not asserted");
   a_rcs_cleared: assert property (dual_buffer_enable && cyc_read && !cyc_write && // [RULE4]
                                   !read_address_reg[`BIT_CHIP_SELECT]
                                   |=> !chip_select_one && address_line_fourteen)
      else $error("read select clear did not give address 14");
   a_common_mode: assert property (!dual_buffer_enable && cyc_write && !wr_cad // [RULE5]
                                   |=> pin_addr == $past(common_address_reg[ADDR_W-1:0]))
      else $error("common address not used outside dual mode");
   a_dual_write_addr: assert property (dual_buffer_enable && cyc_write && !wr_wad // [RULE5]
                                       |=> pin_addr == $past(write_address_reg[ADDR_W-1:0]))
      else $error("write cycle did not use write address");
   a_capture_dual: assert property (cap_dual |=> // [RULE6]
                                    read_input_data_reg[DATA_W-1:0] == $past(data_sync_reg))
      else $error("read word not captured");
   a_capture_common: assert property (cap_common && !wr_rdin |=> // [RULE7]
                                      $stable(read_input_data_reg) &&
                                      common_data_input_reg[DATA_W-1:0] ==
                                      $past(data_sync_reg))
      else $error("capture went to wrong register outside dual mode");
   a_common_hold: assert property (cap_dual && !wr_cdin |=> // [RULE7]
                                   $stable(common_data_input_reg))
      else $error("dual mode capture reached the common input register");
   a_upper_zero: assert property (reg_rd ##1 1'b1 |-> // [RULE8]
                                  reg_rdata_reg[31:16] == 16'h0000 ||
                                  $past(reg_addr) == `OFS_PORT_CONTROL)
      else $error("unimplemented bits read nonzero");
   a_addr_unused_zero: assert property ( // [RULE8]
      (write_address_reg & ~`MASK_ADDRESS) == 32'h0000_0000 &&
      (read_address_reg & ~`MASK_ADDRESS) == 32'h0000_0000)
      else $error("unused address bits hold ones");
   a_dual_read_addr: assert property (dual_buffer_enable && cyc_read && !cyc_write && // [RULE9]
                                      !wr_rad
                                      |=> pin_addr == $past(read_address_reg[ADDR_W-1:0]))
      else $error("read cycle did not use read address");
   a_idle_pins: assert property (!cyc_write && !cyc_read |=> // [RULE9]
                                 pin_addr == '0 && !chip_select_one && !address_line_fourteen)
      else $error("pins active outside an external cycle");
   a_reset_clear: assert property ($past(sys_rst) |-> // [RULE10]
                                   write_address_reg == `RESET_REG &&
                                   read_address_reg == `RESET_REG &&
                                   read_input_data_reg == `RESET_REG && !chip_select_one)
      else $error("registers not clear after reset");

   c_dual_write: cover property (dual_buffer_enable && cyc_write ##1 chip_select_one);
   c_dual_read: cover property (dual_buffer_enable && cyc_read ##1 address_line_fourteen);
   c_capture: cover property (cap_dual ##2 reg_rd);
   c_common: cover property (cap_common);
endmodule

// ---- sim/ext_device.sv ----
// Behavioural model of the external parallel device
`timescale 1ns/1ns
module ext_device (
   // Clock
   input  wire logic        clk,
   // Address and select pins
   input  wire logic [10:0] pin_addr,
   input  wire logic        chip_select_one,
   input  wire logic        address_line_fourteen,
   // Data pins
   output logic      [15:0] ext_data_in
);
   logic [15:0] last_reg = 16'h0000;
   wire         sel_w = chip_select_one | address_line_fourteen;
   // Unselected bus toggles every cycle so stale data can never pass for an answer
   assign ext_data_in = sel_w ? {~pin_addr[4:0], pin_addr} : ~last_reg;
   always @(posedge clk) begin
      last_reg <= ext_data_in;
   end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the dual-buffer register block
`timescale 1ns/1ns
module tb
   import pp_dual_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, read_capture = 1'b0;
   logic        cyc_write = 1'b0, cyc_read = 1'b0, rd_d = 1'b0, cyc_d = 1'b0;
   wire  [31:0] reg_rdata_reg;
   wire  [10:0] pin_addr;
   wire  [15:0] ext_data_in;
   wire         chip_select_one, address_line_fourteen, dual_buffer_enable;
   wire  [12:0] pin_bus = {address_line_fourteen, chip_select_one, pin_addr};
   reg_word_t   rq[$];
   logic [12:0] pq[$];
   reg_word_t   w, r, c;
   int          miscompares = 0, cmp_count = 0, seed = 10;
   reg_word_t   msk[7] = '{32'h0002_0000, 32'h0000_47FF, 32'h0000_47FF, 32'h0000_FFFF,
                          32'h0000_FFFF, 32'h0000_47FF, 32'h0000_0000};

   initial forever #5 clk = ~clk;

   parallel_port_dual_buffer_regs i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata_reg, .cyc_write, .cyc_read, .read_capture, .ext_data_in,
      .pin_addr, .chip_select_one, .address_line_fourteen, .dual_buffer_enable);
   ext_device i_dev (.clk, .pin_addr, .chip_select_one, .address_line_fourteen, .ext_data_in);

   function automatic logic [12:0] pins(reg_word_t v);
      return {~v[14], v[14], v[10:0]};
   endfunction
   function automatic reg_word_t word(reg_word_t v);
      return {16'h0000, ~v[4:0], v[10:0]};
   endfunction

   task automatic check_word(reg_word_t e, reg_word_t g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] reg_rdata_reg expected %h seen %h", e, g);
      end
   endtask
   task automatic check_pins(logic [12:0] e, logic [12:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] pins expected %h seen %h", e, g);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(logic [7:0] a, reg_word_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, reg_word_t e);
      @(posedge clk);
      rq.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // External cycle held n clocks; a read captures the pins' data in its last clock
   task automatic cyc(logic wv, logic rv, logic [12:0] e, int n);
      @(posedge clk);
      cyc_write <= wv;
      cyc_read <= rv;
      repeat (n) pq.push_back(e);
      repeat (n - 1) @(posedge clk);
      read_capture <= rv & ~wv;
      @(posedge clk);
      cyc_write <= 1'b0;
      cyc_read <= 1'b0;
      read_capture <= 1'b0;
   endtask

   // Idle pins must sit at zero; the first edge in reset still shows unreset flops
   always @(posedge clk) begin
      if (rd_d) check_word(rq.pop_front(), reg_rdata_reg);
      if (cyc_d) check_pins(pq.pop_front(), pin_bus);
      else if (!sys_rst) check_pins(13'h0000, pin_bus);
      rd_d <= reg_rd;
      cyc_d <= cyc_write | cyc_read;
   end

   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 28; a += 4) rd(a[7:0], 32'h0);
      for (int a = 0; a < 28; a += 4) wr(a[7:0], 32'hFFFF_FFFF);
      for (int a = 0; a < 28; a += 4) rd(a[7:0], msk[a/4]);
      check_word(32'h1, {31'h0, dual_buffer_enable});
      for (int i = 0; i < 8; i++) begin
         w = $random(seed);
         r = $random(seed);
         wr(8'h04, w);
         wr(8'h08, r);
         cyc(1'b1, 1'b0, pins(w), 2);
         cyc(1'b0, 1'b1, pins(r), 4);
         rd(8'h0C, word(r));
         rd(8'h04, w & 32'h0000_47FF);
         rd(8'h08, r & 32'h0000_47FF);
      end
      rd(8'h10, 32'h0000_FFFF);
      cyc(1'b1, 1'b1, pins(w), 1);
      wr(8'h00, 32'h0);
      c = $random(seed);
      wr(8'h14, c);
      cyc(1'b1, 1'b0, pins(c), 1);
      cyc(1'b0, 1'b1, pins(c), 4);
      rd(8'h10, word(c));
      rd(8'h0C, word(r));
      repeat (3) @(posedge clk);
      stop_test();
   end

   // Run needs about 220 clocks; reaching 10000 clocks means a hang
   initial begin
      #100000;
      miscompares++;
      stop_test();
   end
endmodule
